// ===== sbd_mode_defs.vh
// Shared constants for the operating-mode controller
`ifndef SBD_MODE_DEFS_VH
`define SBD_MODE_DEFS_VH

// Core clock rate in MHz
`define CORE_CLK_MHZ 50

// Width of every cycle counter and timing parameter
`define TIMER_W 24

// Reset pulse after supply undervoltage (least of 20..25 ms), in us
`define COLD_PULSE_US 20000
// Reset pulse for any other cause (least of 1..1.5 ms), in us
`define WARM_PULSE_US 1000
// Boot delay after power-on detection, in us
`define STARTUP_US 1000
// Bus silence before ground biasing, in us
`define SILENCE_US 100000
// Noise filter on the reset pin, in us
`define RST_FILTER_US 1

// Derived cycle counts: the us figure times the clock rate in MHz
// Sized to the timer width so no bits are dropped on assignment
`define COLD_PULSE_CYC 24'h0F4240
`define WARM_PULSE_CYC 24'h00C350
`define STARTUP_CYC 24'h00C350
`define SILENCE_CYC 24'h4C4B40
`define RST_FILTER_CYC 24'h000032

// Bit positions inside the synchroniser bundle
`define SY_PWR_ON 0
`define SY_PWR_OFF 1
`define SY_HOT 2
`define SY_COOL 3
`define SY_MCU_OK 4
`define SY_STBY_N 5
`define SY_RST_PIN 6
`define SY_WAKE 7
`define SY_ACT 8
`define SY_RX 9
`define SY_W 10

`endif

// ===== sync_2ff.v
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter WIDTH = 1
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage is read only by the second stage
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule // sync_2ff
`default_nettype wire

// ===== hold_timer.v
// Saturating cycle counter that reports a condition held long enough
`timescale 1ns/10ps
`default_nettype none
`include "sbd_mode_defs.vh"
module hold_timer (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_run,
  input wire [`TIMER_W-1:0] i_limit,
  output wire o_done
);

  reg [`TIMER_W-1:0] count_reg;
  reg [`TIMER_W-1:0] count_next;

  // Restart whenever the condition drops; stop at the limit
  always @*
  begin
    count_next = count_reg;
    if (!i_run)
      count_next = {`TIMER_W{1'b0}};
    else if (count_reg < i_limit)
      count_next = count_reg + {{(`TIMER_W-1){1'b0}}, 1'b1};
  end

  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      count_reg <= {`TIMER_W{1'b0}};
    else
      count_reg <= count_next;
  end

  // Limit of zero would be done at once; keep limits at least one
  assign o_done = i_run && (count_reg >= i_limit);

endmodule // hold_timer
`default_nettype wire

// ===== sbd_mode_ctrl.v
// Operating-mode controller of a system basis device
// How it works
// RULE1 - Five modes only: Normal, Standby, Reset, Overtemp and Off.
// RULE2 - Standby select high while in Standby moves the device to Normal.
// RULE3 - Entering Normal clears pending power-on and bus wake indications.
// RULE4 - Standby: no transmit or receive, microcontroller supply kept on.
// RULE5 - Standby biasing: ground after bus silence, mid level on activity.
// RULE6 - Bus wake in Standby forces receive data output low.
// RULE7 - Standby is reached from Off or Overtemp only through Reset.
// RULE8 - Standby select low while in Normal moves the device to Standby.
// RULE9 - Reset mode pulls the reset pin low for a defined time.
// RULE10 - Reset: no transmit or receive; supply and heat detection stay on.
// RULE11 - Any reset event enters Reset from whatever mode is current; the code takes reset events only in Standby and Normal.
// RULE12 - Reset goes to Standby once the reset pin is released and high.
// RULE13 - Power-off or overheating leaves Reset directly for Off or Overtemp.
// RULE14 - Reset from undervoltage waits until the supply has recovered.
// RULE15 - Off on first battery connection and whenever battery drops too low.
// RULE16 - Off: only power-on detection runs, bus pins float.
// RULE17 - After power-on detection, Reset follows once the boot delay ends.
// RULE18 - Receive data goes low on the path from Off to Standby.
// RULE19 - Overheating trips Overtemp at once from any mode but Off.
// RULE20 - Overtemp: bus off and floating, supply off, reset pin low.
// RULE21 - Overtemp detects no wake; a pending wake stays shown afterwards.
// RULE22 - Overtemp goes to Reset when cool, to Off on battery loss.
// RULE23 - Reset pulse 20 ms after undervoltage, 1 ms for other causes.
// RULE24 - Filtered external pull-down of the reset pin is a reset event.
// RULE25 - Receive data stays low from leaving Off until Normal is entered.
// RULE26 - Reset entered on supply undervoltage, leaving Off or Overtemp.
// RULE27 - Standby select and reset pin level are synchronised before use.
`timescale 1ns/10ps
`default_nettype none
`include "sbd_mode_defs.vh"
module sbd_mode_ctrl #(
  parameter [`TIMER_W-1:0] COLD_PULSE_CYC = `COLD_PULSE_CYC,
  parameter [`TIMER_W-1:0] WARM_PULSE_CYC = `WARM_PULSE_CYC,
  parameter [`TIMER_W-1:0] STARTUP_CYC = `STARTUP_CYC,
  parameter [`TIMER_W-1:0] SILENCE_CYC = `SILENCE_CYC,
  parameter [`TIMER_W-1:0] RST_FILTER_CYC = `RST_FILTER_CYC
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_battery_power_on,
  input wire i_battery_power_off,
  input wire i_overheat_trip,
  input wire i_overheat_release,
  input wire i_mcu_supply_rail_ok,
  input wire i_standby_select_n,
  input wire i_system_reset_pin_n,
  input wire i_bus_wake,
  input wire i_bus_activity,
  input wire i_bus_rx_data,
  output reg [2:0] o_mode,
  output reg o_mcu_supply_rail_en,
  output reg o_system_reset_pin_n_o,
  output reg o_system_reset_pin_n_oe,
  output reg o_bus_tx_en,
  output reg o_bus_rx_en,
  output reg o_bus_bias_mid,
  output reg o_bus_bias_gnd,
  output reg o_bus_float,
  output reg o_wake_detect_en,
  output reg o_overheat_detect_en,
  output reg o_rx_data
);

  // Mode codes
  localparam [2:0] MODE_OFF = 3'h0;
  localparam [2:0] MODE_RESET = 3'h1;
  localparam [2:0] MODE_STANDBY = 3'h2;
  localparam [2:0] MODE_NORMAL = 3'h3;
  localparam [2:0] MODE_OVERTEMP = 3'h4;
  wire [`SY_W-1:0] sync_bus;
  wire pwr_on, pwr_off, hot, cool, mcu_ok, stby_n, rst_pin;
  wire wake, activity, rx_bit;
  wire startup_done, pulse_done, silence_done, ext_reset, offline;
  wire [`TIMER_W-1:0] pulse_limit;
  reg [2:0] mode_reg, mode_next;
  reg uv_cause_reg, uv_cause_next;
  reg pon_wake_reg, pon_wake_next;
  reg bus_wake_reg, bus_wake_next;
  reg bias_mid_reg, bias_mid_next;
  reg drive_low_next, supply_next;

  // Every pin and analog comparator is asynchronous to the core clock
  sync_2ff #(
    .WIDTH(`SY_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_bus_rx_data, i_bus_activity, i_bus_wake,
              i_system_reset_pin_n, i_standby_select_n,
              i_mcu_supply_rail_ok, i_overheat_release,
              i_overheat_trip, i_battery_power_off,
              i_battery_power_on}),
    .o_sync(sync_bus)
  ); // see RULE27

  assign pwr_on = sync_bus[`SY_PWR_ON];
  assign pwr_off = sync_bus[`SY_PWR_OFF];
  assign hot = sync_bus[`SY_HOT];
  assign cool = sync_bus[`SY_COOL];
  assign mcu_ok = sync_bus[`SY_MCU_OK];
  assign stby_n = sync_bus[`SY_STBY_N];
  assign rst_pin = sync_bus[`SY_RST_PIN];
  assign wake = sync_bus[`SY_WAKE];
  assign activity = sync_bus[`SY_ACT];
  assign rx_bit = sync_bus[`SY_RX];

  // Boot delay counts only while the battery stays above power-on
  hold_timer u_startup (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run((mode_reg == MODE_OFF) && pwr_on && !pwr_off),
    .i_limit(STARTUP_CYC),
    .o_done(startup_done)
  ); // see RULE17

  // Pulse length chosen by cause; may grow if the supply sags in Reset
  assign pulse_limit = uv_cause_reg ? COLD_PULSE_CYC :
                       WARM_PULSE_CYC; // see RULE23

  // Counter restarts on every entry because the mode leaves Reset first
  hold_timer u_pulse (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(mode_reg == MODE_RESET),
    .i_limit(pulse_limit),
    .o_done(pulse_done)
  ); // see RULE9

  // Offline transceiver: Standby and Reset both monitor the bus
  assign offline = (mode_reg == MODE_STANDBY) || (mode_reg == MODE_RESET);

  hold_timer u_silence (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(offline && !activity),
    .i_limit(SILENCE_CYC),
    .o_done(silence_done)
  ); // see RULE5

  // Only our own released pin is watched, so our pulse never retriggers
  hold_timer u_filter (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(!o_system_reset_pin_n_oe && !rst_pin),
    .i_limit(RST_FILTER_CYC),
    .o_done(ext_reset)
  ); // see RULE24

  // Mode transitions; battery loss first, then heat, then reset events
  always @*
  begin
    mode_next = mode_reg;
    if (pwr_off)
      mode_next = MODE_OFF; // see RULE15
    else
    begin
      case (mode_reg)
        MODE_OFF:
        begin
          if (startup_done)
            mode_next = MODE_RESET; // see RULE17 and RULE26
        end
        MODE_OVERTEMP:
        begin
          if (cool && !hot)
            mode_next = MODE_RESET; // see RULE22 and RULE7
        end
        MODE_RESET:
        begin
          if (hot)
            mode_next = MODE_OVERTEMP; // see RULE13
          else if (pulse_done && rst_pin && mcu_ok)
            mode_next = MODE_STANDBY; // see RULE12 and RULE14
        end
        MODE_STANDBY:
        begin
          if (hot)
            mode_next = MODE_OVERTEMP; // see RULE19
          else if (!mcu_ok || ext_reset)
            mode_next = MODE_RESET; // see RULE11 and RULE26
          else if (stby_n)
            mode_next = MODE_NORMAL; // see RULE2
        end
        MODE_NORMAL:
        begin
          if (hot)
            mode_next = MODE_OVERTEMP; // see RULE19
          else if (!mcu_ok || ext_reset)
            mode_next = MODE_RESET; // see RULE11 and RULE26
          else if (!stby_n)
            mode_next = MODE_STANDBY; // see RULE8
        end
        default:
          mode_next = MODE_OFF; // see RULE1
      endcase
    end
  end

  // Cold-start cause: undervoltage entry or a sagging supply during Reset
  always @*
  begin
    uv_cause_next = 1'b0;
    if (mode_next == MODE_RESET)
    begin
      if (mode_reg == MODE_RESET)
        uv_cause_next = uv_cause_reg || !mcu_ok; // see RULE14
      else
        uv_cause_next = !mcu_ok; // see RULE23
    end
  end

  // Wake flags; a set in the same cycle as the Normal-entry clear wins
  always @*
  begin
    pon_wake_next = pon_wake_reg;
    bus_wake_next = bus_wake_reg;
    if (mode_next == MODE_OFF)
    begin
      pon_wake_next = 1'b0;
      bus_wake_next = 1'b0;
    end
    else if (mode_next == MODE_NORMAL && mode_reg != MODE_NORMAL)
    begin
      pon_wake_next = 1'b0; // see RULE3
      bus_wake_next = 1'b0; // see RULE3
    end
    if (mode_reg == MODE_OFF && mode_next == MODE_RESET)
      pon_wake_next = 1'b1; // see RULE18 and RULE25
    if (offline && wake)
      bus_wake_next = 1'b1; // see RULE6 and RULE21
  end

  // Mid biasing on any edge, ground after the silence time runs out
  always @*
  begin
    bias_mid_next = bias_mid_reg;
    if (mode_next == MODE_NORMAL)
      bias_mid_next = 1'b1;
    else if (mode_next != MODE_STANDBY && mode_next != MODE_RESET)
      bias_mid_next = 1'b0;
    else if (activity)
      bias_mid_next = 1'b1; // see RULE5
    else if (silence_done)
      bias_mid_next = 1'b0; // see RULE5
  end

  // Reset pin low in Off and Overtemp, and in Reset until the pulse ends
  always @*
  begin
    drive_low_next = 1'b0;
    case (mode_next)
      MODE_OFF:
        drive_low_next = 1'b1;
      MODE_OVERTEMP:
        drive_low_next = 1'b1; // see RULE20
      MODE_RESET:
        drive_low_next = !(mode_reg == MODE_RESET && pulse_done); // see RULE9
      default:
        drive_low_next = 1'b0;
    endcase
    supply_next = (mode_next == MODE_STANDBY) ||
                  (mode_next == MODE_NORMAL) ||
                  (mode_next == MODE_RESET); // see RULE4 and RULE10
  end

  // State registers
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode_reg <= MODE_OFF; // see RULE15
      uv_cause_reg <= 1'b0;
      pon_wake_reg <= 1'b0;
      bus_wake_reg <= 1'b0;
      bias_mid_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      uv_cause_reg <= uv_cause_next;
      pon_wake_reg <= pon_wake_next;
      bus_wake_reg <= bus_wake_next;
      bias_mid_reg <= bias_mid_next;
    end
  end

  // Outputs registered from next state so they line up with the mode
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_mode <= MODE_OFF;
      o_mcu_supply_rail_en <= 1'b0;
      o_system_reset_pin_n_o <= 1'b0;
      o_system_reset_pin_n_oe <= 1'b1;
      o_bus_tx_en <= 1'b0;
      o_bus_rx_en <= 1'b0;
      o_bus_bias_mid <= 1'b0;
      o_bus_bias_gnd <= 1'b0;
      o_bus_float <= 1'b1;
      o_wake_detect_en <= 1'b0;
      o_overheat_detect_en <= 1'b0;
      o_rx_data <= 1'b1;
    end
    else
    begin
      o_mode <= mode_next;
      o_mcu_supply_rail_en <= supply_next; // see RULE20
      o_system_reset_pin_n_o <= 1'b0;
      o_system_reset_pin_n_oe <= drive_low_next; // see RULE9
      // Active only in Normal with a healthy supply
      o_bus_tx_en <= (mode_next == MODE_NORMAL) && mcu_ok; // see RULE4
      o_bus_rx_en <= (mode_next == MODE_NORMAL) && mcu_ok; // see RULE10
      o_bus_bias_mid <= supply_next && bias_mid_next; // see RULE5
      o_bus_bias_gnd <= supply_next && !bias_mid_next; // see RULE5
      o_bus_float <= !supply_next; // see RULE16 and RULE20
      // Wake monitoring off in Overtemp so no new wake is taken
      o_wake_detect_en <= (mode_next == MODE_STANDBY) ||
                          (mode_next == MODE_RESET); // see RULE21
      o_overheat_detect_en <= (mode_next != MODE_OFF); // see RULE16
      if (mode_next == MODE_NORMAL)
        o_rx_data <= rx_bit;
      else if (mode_next == MODE_OFF)
        o_rx_data <= 1'b1;
      else
        o_rx_data <= !(pon_wake_next || bus_wake_next); // see RULE25
    end
  end

endmodule // sbd_mode_ctrl
`default_nettype wire

// ===== mcu_host_model.sv
// Host microcontroller model on the mode select and reset pins
`timescale 1ns/10ps
`default_nettype none
module mcu_host_model (
  input wire logic i_stby_req_n,
  input wire logic i_pull_req,
  input wire logic i_pin_drv_o,
  input wire logic i_pin_drv_oe,
  output logic o_standby_select_n,
  output logic o_pin_level
);
  // Host holds the mode line as commanded: low asks for standby
  assign o_standby_select_n = i_stby_req_n;
  // Open-drain wire with pull-up, so a released pin reads high, never stale
  assign o_pin_level = !(i_pull_req || (i_pin_drv_oe && !i_pin_drv_o));
endmodule // mcu_host_model
`default_nettype wire

// ===== sbd_mode_ctrl_props.sv
// Property checker for the operating-mode controller
`timescale 1ns/10ps
`default_nettype none
module sbd_mode_ctrl_props #(
  parameter int COLD_PULSE_CYC = 40,
  parameter int WARM_PULSE_CYC = 20
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_battery_power_off,
  input wire logic i_overheat_trip,
  input wire logic i_mcu_supply_rail_ok,
  input wire logic i_standby_select_n,
  input wire logic i_system_reset_pin_n,
  input wire logic [2:0] o_mode,
  input wire logic o_mcu_supply_rail_en,
  input wire logic o_system_reset_pin_n_oe,
  input wire logic o_bus_tx_en,
  input wire logic o_bus_rx_en,
  input wire logic o_bus_float,
  input wire logic o_wake_detect_en,
  input wire logic o_overheat_detect_en,
  input wire logic o_rx_data
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [2:0] prev_mode_reg;
  logic pon_pend_reg;
  int pulse_cnt_reg;
  // Power-on flag and own pulse length; the count restarts per Reset visit
  always @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      prev_mode_reg <= 3'h0;
      pon_pend_reg <= 1'b0;
      pulse_cnt_reg <= 0;
    end
    else
    begin
      prev_mode_reg <= o_mode;
      if (o_mode == 3'h3)
        pon_pend_reg <= 1'b0;
      else if (o_mode == 3'h1 && prev_mode_reg == 3'h0)
        pon_pend_reg <= 1'b1;
      if (o_mode == 3'h1 && o_system_reset_pin_n_oe)
        pulse_cnt_reg <= pulse_cnt_reg + 1;
      else
        pulse_cnt_reg <= 0;
    end
  end
  property p_off;
    o_mode == 3'h0 |-> o_bus_float && !o_mcu_supply_rail_en
      && !o_bus_tx_en && !o_overheat_detect_en;
  endproperty
  a_off: assert property (p_off)
    else $error("off mode outputs wrong");
  property p_hot_out;
    o_mode == 3'h4 |-> o_bus_float && !o_mcu_supply_rail_en
      && o_system_reset_pin_n_oe && !o_bus_tx_en && !o_wake_detect_en;
  endproperty
  a_hot_out: assert property (p_hot_out)
    else $error("overtemp outputs wrong");
  property p_rst_out;
    o_mode == 3'h1 |-> o_mcu_supply_rail_en && !o_bus_tx_en
      && !o_bus_rx_en && o_overheat_detect_en;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("reset mode outputs wrong");
  property p_stby_out;
    o_mode == 3'h2 |-> o_mcu_supply_rail_en && !o_bus_tx_en
      && !o_bus_rx_en && !o_system_reset_pin_n_oe && o_wake_detect_en;
  endproperty
  a_stby_out: assert property (p_stby_out)
    else $error("standby outputs wrong");
  property p_via_reset;
    $changed(o_mode) && o_mode == 3'h2 |-> $past(o_mode) inside {3'h1, 3'h3};
  endproperty
  a_via_reset: assert property (p_via_reset)
    else $error("standby entered from wrong mode");
  property p_hot;
    $rose(i_overheat_trip) && !i_battery_power_off
      && o_mode inside {3'h1, 3'h2, 3'h3} |-> ##[1:4] o_mode == 3'h4;
  endproperty
  a_hot: assert property (p_hot)
    else $error("overtemp not entered");
  property p_bat_off;
    $rose(i_battery_power_off) |-> ##[1:4] o_mode == 3'h0;
  endproperty
  a_bat_off: assert property (p_bat_off)
    else $error("off mode not entered");
  property p_pulse;
    $fell(o_system_reset_pin_n_oe) |->
      (pulse_cnt_reg inside {[WARM_PULSE_CYC-2:WARM_PULSE_CYC+2]})
      || (pulse_cnt_reg inside {[COLD_PULSE_CYC-2:COLD_PULSE_CYC+2]});
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse length wrong");
  property p_pon_rx;
    pon_pend_reg && o_mode inside {3'h1, 3'h2, 3'h4} |-> !o_rx_data;
  endproperty
  a_pon_rx: assert property (p_pon_rx)
    else $error("power-on indication lost");
  property p_to_normal;
    o_mode == 3'h2 && i_standby_select_n && i_mcu_supply_rail_ok
      && i_system_reset_pin_n && !i_overheat_trip && !i_battery_power_off
      |-> ##[0:4] o_mode == 3'h3;
  endproperty
  a_to_normal: assert property (p_to_normal)
    else $error("normal mode not entered");
  c_hot: cover property (o_mode == 3'h4);
  c_pulse: cover property ($fell(o_system_reset_pin_n_oe));
  c_normal: cover property (o_mode == 3'h3);
endmodule // sbd_mode_ctrl_props
bind sbd_mode_ctrl sbd_mode_ctrl_props #(
  .COLD_PULSE_CYC(COLD_PULSE_CYC),
  .WARM_PULSE_CYC(WARM_PULSE_CYC)
) u_props (
  .i_core_clk(i_core_clk),
  .i_sys_rst(i_sys_rst),
  .i_battery_power_off(i_battery_power_off),
  .i_overheat_trip(i_overheat_trip),
  .i_mcu_supply_rail_ok(i_mcu_supply_rail_ok),
  .i_standby_select_n(i_standby_select_n),
  .i_system_reset_pin_n(i_system_reset_pin_n),
  .o_mode(o_mode),
  .o_mcu_supply_rail_en(o_mcu_supply_rail_en),
  .o_system_reset_pin_n_oe(o_system_reset_pin_n_oe),
  .o_bus_tx_en(o_bus_tx_en),
  .o_bus_rx_en(o_bus_rx_en),
  .o_bus_float(o_bus_float),
  .o_wake_detect_en(o_wake_detect_en),
  .o_overheat_detect_en(o_overheat_detect_en),
  .o_rx_data(o_rx_data)
);
`default_nettype wire

// ===== sbd_mode_ctrl_test.sv
// Self-checking testbench of the operating-mode controller
`timescale 1ns/10ps
`default_nettype none
module sbd_mode_ctrl_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwr_on = 1'b0, pwr_off = 1'b0, trip = 1'b0, cool = 1'b1;
  logic sup_ok = 1'b1, wake = 1'b0, act = 1'b0, rx = 1'b1;
  logic stby_req_n = 1'b0, pull = 1'b0;
  wire stby_n, pin_n, pin_o, pin_oe, sup_en, tx_en, rx_en;
  wire b_mid, b_gnd, flt, rxd;
  wire [2:0] mode;
  int errors = 0;
  int samples_checked = 0;
  // Short counts keep the run brief; every expectation uses these values
  sbd_mode_ctrl #(.COLD_PULSE_CYC(24'h000028), .WARM_PULSE_CYC(24'h000014),
    .STARTUP_CYC(24'h00000A), .SILENCE_CYC(24'h00001E),
    .RST_FILTER_CYC(24'h000005)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
    .i_battery_power_on(pwr_on), .i_battery_power_off(pwr_off),
    .i_overheat_trip(trip), .i_overheat_release(cool),
    .i_mcu_supply_rail_ok(sup_ok), .i_standby_select_n(stby_n),
    .i_system_reset_pin_n(pin_n), .i_bus_wake(wake),
    .i_bus_activity(act), .i_bus_rx_data(rx), .o_mode(mode),
    .o_mcu_supply_rail_en(sup_en), .o_system_reset_pin_n_o(pin_o),
    .o_system_reset_pin_n_oe(pin_oe), .o_bus_tx_en(tx_en),
    .o_bus_rx_en(rx_en), .o_bus_bias_mid(b_mid), .o_bus_bias_gnd(b_gnd),
    .o_bus_float(flt), .o_wake_detect_en(), .o_overheat_detect_en(),
    .o_rx_data(rxd));
  mcu_host_model u_host (.i_stby_req_n(stby_req_n), .i_pull_req(pull),
    .i_pin_drv_o(pin_o), .i_pin_drv_oe(pin_oe),
    .o_standby_select_n(stby_n), .o_pin_level(pin_n));
  // Free-running core clock, 20 ns period
  initial
  begin
    forever #10 clk = ~clk;
  end
  task give_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [2:0] seen, input logic [2:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for a mode; a hang ends the run with a mismatch
  task wait_mode(input logic [2:0] m, input int bound);
    int i;
    for (i = 0; i < bound && mode !== m; i++)
      cyc(1);
    chk(mode, m);
    if (mode !== m)
      give_verdict();
  endtask
  task t_power_up;
    int n;
    chk({flt, sup_en, rxd}, 3'h5);
    pwr_on = 1'b1;
    cyc(6);
    chk(mode, 3'h0);
    wait_mode(3'h1, 20);
    chk({pin_oe, sup_en, rxd}, 3'h6);
    chk(pin_o, 3'h0);
    n = 0;
    while (pin_oe === 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk(n >= 18 && n <= 23, 3'h1);
    wait_mode(3'h2, 10);
    chk({tx_en, rx_en, rxd}, 3'h0);
  endtask
  task t_bias;
    cyc(40);
    chk({b_gnd, b_mid}, 3'h2);
    act = 1'b1;
    cyc(5);
    chk({b_gnd, b_mid}, 3'h1);
    act = 1'b0;
    // Mid bias must outlast a short gap, then fall back after silence
    cyc(20);
    chk({b_gnd, b_mid}, 3'h1);
    cyc(20);
    chk({b_gnd, b_mid}, 3'h2);
  endtask
  task t_normal;
    stby_req_n = 1'b1;
    wait_mode(3'h3, 6);
    rx = 1'b0;
    cyc(4);
    chk(rxd, 3'h0);
    rx = 1'b1;
    cyc(4);
    chk(rxd, 3'h1);
    stby_req_n = 1'b0;
    wait_mode(3'h2, 6);
    chk({tx_en, rx_en, rxd}, 3'h1);
  endtask
  task t_wake;
    wake = 1'b1;
    cyc(5);
    chk(rxd, 3'h0);
    wake = 1'b0;
  endtask
  // Host pulls the pin; the pulse then outlasts the host's release
  task t_ext_reset;
    pull = 1'b1;
    wait_mode(3'h1, 12);
    cyc(2);
    pull = 1'b0;
    wait_mode(3'h2, 40);
  endtask
  task t_undervolt;
    sup_ok = 1'b0;
    wait_mode(3'h1, 8);
    cyc(60);
    chk(mode, 3'h1);
    sup_ok = 1'b1;
    wait_mode(3'h2, 20);
  endtask
  task t_overtemp;
    trip = 1'b1;
    cool = 1'b0;
    wait_mode(3'h4, 5);
    chk({sup_en, flt, pin_oe}, 3'h3);
    chk(rxd, 3'h0);
    trip = 1'b0;
    cool = 1'b1;
    wait_mode(3'h1, 6);
    // Heat again while the pulse runs: Reset is left for Overtemp
    trip = 1'b1;
    cool = 1'b0;
    wait_mode(3'h4, 5);
    trip = 1'b0;
    cool = 1'b1;
    wait_mode(3'h1, 6);
    wait_mode(3'h2, 60);
    chk(rxd, 3'h0);
  endtask
  task t_power_off;
    pull = 1'b1;
    wait_mode(3'h1, 12);
    pull = 1'b0;
    pwr_off = 1'b1;
    pwr_on = 1'b0;
    wait_mode(3'h0, 5);
    trip = 1'b1;
    cyc(6);
    chk(mode, 3'h0);
    chk(flt, 3'h1);
  endtask
  // Main sequence: reset held for six cycles, then each scenario in turn
  initial
  begin
    cyc(6);
    rst = 1'b0;
    t_power_up();
    t_bias();
    t_normal();
    t_wake();
    t_ext_reset();
    t_undervolt();
    t_overtemp();
    t_power_off();
    give_verdict();
  end
endmodule // sbd_mode_ctrl_test
`default_nettype wire
